/* File: core/acr_pkg.sv */
// Purpose: shared constants for the clock and range configuration block
// Assumes: one 40 MHz clock for both ends
// Notes:   device registers are 8 bits wide, 4-bit address
package acr_pkg;
  // ----------------------------------------------------------------
  // device register map
  // ----------------------------------------------------------------
  localparam logic [3:0] CLOCK_CONFIG_REG    = 4'h0;
  localparam logic [3:0] ANALOG_CONFIG_REG   = 4'h1;
  localparam logic [3:0] PRIMARY_STATUS_REG  = 4'h2;
  localparam logic [3:0] DEV_INT_STATUS_REG  = 4'h3;
  localparam logic [3:0] DEV_INT_MASK_REG    = 4'h4;
  // clock_config_reg fields
  localparam int CLK_SEL_BIT  = 0;
  localparam int DIV_LSB      = 1;
  localparam logic [2:0] DIV_LOG2_MAX = 3'h4;
  // analog_config_reg fields
  localparam int INPUT_RANGE_BIT = 0;
  localparam int REF_RANGE_BIT   = 1;
  localparam int EXT_RANGE_BIT   = 2;
  localparam int POS_BUF_BIT     = 3;
  localparam int NEG_BUF_BIT     = 4;
  localparam int REF_BUF_BIT     = 5;
  localparam logic [7:0] CLOCK_CONFIG_RESET  = 8'h00;
  localparam logic [5:0] ANALOG_CONFIG_RESET = 6'h00;
  // device interrupt bits
  localparam int DEV_INT_SAT  = 0;
  localparam int DEV_INT_IGN  = 1;
  // ----------------------------------------------------------------
  // host register map
  // ----------------------------------------------------------------
  localparam logic [3:0] HOST_DEV_ADDR_REG  = 4'h0;
  localparam logic [3:0] HOST_DEV_WDATA_REG = 4'h1;
  localparam logic [3:0] HOST_DEV_RD_REG    = 4'h2;
  localparam logic [3:0] HOST_DEV_RDATA_REG = 4'h3;
  localparam logic [3:0] HOST_CTRL_REG      = 4'h4;
  localparam logic [3:0] HOST_INT_STAT_REG  = 4'h5;
  localparam logic [3:0] HOST_INT_MASK_REG  = 4'h6;
  localparam logic [3:0] HOST_STATUS_REG    = 4'h7;
  localparam int CTRL_EXT_EN    = 0;
  localparam int CTRL_MAX_SPEED = 1;
  localparam int CTRL_DET_SYNC  = 2;
  localparam int HINT_WR_DONE   = 0;
  localparam int HINT_RD_DONE   = 1;
  localparam int HINT_OVERRIDE  = 2;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLOCK_KHZ      = 40000;
  localparam int OSC_KHZ        = 25600;
  // oscillator ticks per 40 MHz cycle as a fraction: 16/25
  localparam logic [4:0] OSC_STEP = 5'h10;
  localparam logic [4:0] OSC_MOD  = 5'h19;
  localparam int IGNORE_US      = 150;
  localparam int IGNORE_TICKS   = IGNORE_US * OSC_KHZ / 1000;
  localparam int EXT_HOLD_EDGES = 4;
  localparam int CONV_MOD_TICKS = 32;
endpackage

/* File: core/acr_link_if.sv */
// Purpose: link between host controller and converter clock block
// Assumes: all signals synchronous to clock
// Notes:   read data valid in the cycle after linkRd
`timescale 1ns/1ps
interface acr_link_if;
  logic       linkWr;
  logic       linkRd;
  logic [3:0] linkAddr;
  logic [7:0] linkWdata;
  logic [7:0] linkRdata;
  logic       extClk;
  logic       startPin;
  logic       resetPin;
  modport device (input linkWr, linkRd, linkAddr, linkWdata, extClk,
                  startPin, resetPin, output linkRdata);
  modport host (output linkWr, linkRd, linkAddr, linkWdata, extClk,
                startPin, resetPin, input linkRdata);
endinterface

/* File: core/acr_device.sv */
// Purpose: converter clock source, divider, pin gating and range config
// Assumes: extClk and pins synchronous to clock; oscillator modelled
//          as a fractional enable at 25.6 MHz
// Notes:   all outputs registered
`timescale 1ns/1ps
// Summary of operation
// - clock select bit picks pin or oscillator
// - divider gives system clock, halved for modulator
// - clock select resets to oscillator
// - oscillator fixed 25.6 MHz, divider for slower
// - host forces pin clock on clock config writes at max speed
// - host keeps pin clock four cycles after switch
// - start and reset pins ignored 3840 ticks of the selected clock, 150 us on the oscillator
// - divide two or sixteen forces mid-speed oversampling
// - host uses divide-by-one for deterministic sync
// - host supplies one pin clock, divided from clock by two times EXT_HALF
// - range bit selects one or two times
// - high reference range forces one-times range
// - reference range bit selects low or high
// - extended range widens full scale 25 percent
// - flag reports modulator saturation
// - separate positive and negative buffer enables
// - reference buffer bypassed halfway through sample
module acr_device
(
  input  wire logic clock,
  input  wire logic rstn,
  acr_link_if.device link,
  input  wire logic modSat,
  output logic      clkSrcExt,
  output logic      sysClkTick,
  output logic      modulatorClock,
  output logic      llOsrForceMid,
  output logic      inputRange2x,
  output logic      referenceRangeHigh,
  output logic      extendedRange,
  output logic      posInputBufferEnable,
  output logic      negInputBufferEnable,
  output logic      refBufferBypass,
  output logic      startOut,
  output logic      resetOut,
  output logic      modulatorSaturationFlag,
  output logic      irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        clkSel;
    logic [2:0]  divLog2;
    logic [5:0]  anaCfg;
    logic [1:0]  intStat;
    logic [1:0]  intMask;
    logic        extPrev;
    logic [4:0]  oscAcc;
    logic [3:0]  divCnt;
    logic        sysTick;
    logic        modClk;
    logic [11:0] ignoreCnt;
    logic        ignoring;
    logic [4:0]  convCnt;
    logic        satLatch;
    logic        satFlag;
    logic [7:0]  rdata;
    logic        inRng2x;
    logic        llForce;
    logic        refBypass;
    logic        startOut;
    logic        resetOut;
    logic        irq;
  } acr_dev_s;

  acr_dev_s st;
  acr_dev_s next_st;

  localparam logic [11:0] IGN_LOAD =
    12'(acr_pkg::IGNORE_TICKS);
  localparam logic [4:0] CONV_LAST =
    5'(acr_pkg::CONV_MOD_TICKS - 1);

  if (acr_pkg::IGNORE_TICKS > 4095)
  begin : g_ign_fit
    $error("ignore count does not fit counter");
  end

  function automatic logic [3:0] div_last(input logic [2:0] l2);
    div_last = 4'((5'h01 << l2) - 5'h01);
  endfunction

  function automatic logic wr_hit(input logic [3:0] a);
    wr_hit = link.linkWr && (link.linkAddr == a);
  endfunction

  logic       srcTick;
  logic       oscTick;
  logic [5:0] oscSum;
  logic       extEdge;
  logic [7:0] clkCfgW;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    clkCfgW = link.linkWdata;
    // oscillator enable at 25.6 MHz from 40 MHz
    oscSum = {1'b0, st.oscAcc} + {1'b0, acr_pkg::OSC_STEP};
    oscTick = (oscSum >= {1'b0, acr_pkg::OSC_MOD});
    next_st.oscAcc = oscTick ? 5'(oscSum - {1'b0, acr_pkg::OSC_MOD})
                             : oscSum[4:0];
    extEdge = link.extClk && !st.extPrev;
    next_st.extPrev = link.extClk;
    srcTick = st.clkSel ? extEdge : oscTick;
    // divider and modulator clock
    next_st.sysTick = 1'b0;
    if (srcTick)
    begin
      if (st.divCnt >= div_last(st.divLog2))
      begin
        next_st.divCnt = 4'h0;
        next_st.sysTick = 1'b1;
      end
      else
        next_st.divCnt = st.divCnt + 4'h1;
    end
    if (st.sysTick)
      next_st.modClk = !st.modClk;
    // reference buffer bypass in second half of sample phase
    next_st.refBypass = st.anaCfg[acr_pkg::REF_BUF_BIT] && next_st.modClk
      && (next_st.divCnt >= 4'(div_last(st.divLog2) >> 1));
    // ignore interval on the selected clock
    if (st.ignoring && srcTick)
    begin
      next_st.ignoreCnt = st.ignoreCnt - 12'h001;
      if (st.ignoreCnt == 12'h001)
      begin
        next_st.ignoring = 1'b0;
        next_st.intStat[acr_pkg::DEV_INT_IGN] = 1'b1;
      end
    end
    // conversion window for saturation latch
    if (st.modClk && st.sysTick)
    begin
      next_st.satLatch = st.satLatch || modSat;
      next_st.convCnt = st.convCnt + 5'h01;
      if (st.convCnt == CONV_LAST)
      begin
        next_st.satFlag = st.satLatch || modSat;
        next_st.satLatch = 1'b0;
        next_st.convCnt = 5'h00;
        if (st.satLatch || modSat)
          next_st.intStat[acr_pkg::DEV_INT_SAT] = 1'b1;
      end
    end
    // register writes
    if (wr_hit(acr_pkg::CLOCK_CONFIG_REG))
    begin
      next_st.clkSel = clkCfgW[acr_pkg::CLK_SEL_BIT];
      next_st.divLog2 = clkCfgW[acr_pkg::DIV_LSB +: 3];
      if (clkCfgW[acr_pkg::DIV_LSB +: 3] > acr_pkg::DIV_LOG2_MAX)
        next_st.divLog2 = acr_pkg::DIV_LOG2_MAX;
      next_st.divCnt = 4'h0;
      if (clkCfgW[acr_pkg::CLK_SEL_BIT] != st.clkSel)
      begin
        next_st.ignoring = 1'b1;
        next_st.ignoreCnt = IGN_LOAD;
      end
    end
    if (wr_hit(acr_pkg::ANALOG_CONFIG_REG))
      next_st.anaCfg = link.linkWdata[5:0];
    if (wr_hit(acr_pkg::DEV_INT_MASK_REG))
      next_st.intMask = link.linkWdata[1:0];
    if (wr_hit(acr_pkg::DEV_INT_STATUS_REG))
      next_st.intStat = (st.intStat & ~link.linkWdata[1:0])
                        | (next_st.intStat & ~st.intStat);
    // pin reset returns configuration to defaults
    if (link.resetPin && !st.ignoring)
    begin
      next_st.clkSel = acr_pkg::CLOCK_CONFIG_RESET[0];
      next_st.divLog2 = acr_pkg::CLOCK_CONFIG_RESET[3:1];
      next_st.anaCfg = acr_pkg::ANALOG_CONFIG_RESET;
      next_st.intMask = 2'h0;
      next_st.divCnt = 4'h0;
      if (st.clkSel)
      begin
        next_st.ignoring = 1'b1;
        next_st.ignoreCnt = IGN_LOAD;
      end
    end
    // register reads
    next_st.rdata = 8'h00;
    if (link.linkRd)
    begin
      case (link.linkAddr)
        acr_pkg::CLOCK_CONFIG_REG:
          next_st.rdata = {4'h0, st.divLog2, st.clkSel};
        acr_pkg::ANALOG_CONFIG_REG:
          next_st.rdata = {2'h0, st.anaCfg};
        acr_pkg::PRIMARY_STATUS_REG:
          next_st.rdata = {5'h00, st.clkSel, st.ignoring, st.satFlag};
        acr_pkg::DEV_INT_STATUS_REG:
          next_st.rdata = {6'h00, st.intStat};
        acr_pkg::DEV_INT_MASK_REG:
          next_st.rdata = {6'h00, st.intMask};
        default:
          next_st.rdata = 8'h00;
      endcase
    end
    // derived outputs
    next_st.inRng2x = next_st.anaCfg[acr_pkg::INPUT_RANGE_BIT]
      && !next_st.anaCfg[acr_pkg::REF_RANGE_BIT];
    next_st.llForce = (next_st.divLog2 == 3'h1)
      || (next_st.divLog2 == 3'h4);
    next_st.startOut = link.startPin && !st.ignoring;
    next_st.resetOut = link.resetPin && !st.ignoring;
    next_st.irq = |(next_st.intStat & next_st.intMask);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign link.linkRdata          = st.rdata;
  assign clkSrcExt               = st.clkSel;
  assign sysClkTick              = st.sysTick;
  assign modulatorClock          = st.modClk;
  assign llOsrForceMid           = st.llForce;
  assign inputRange2x            = st.inRng2x;
  assign referenceRangeHigh      = st.anaCfg[acr_pkg::REF_RANGE_BIT];
  assign extendedRange           = st.anaCfg[acr_pkg::EXT_RANGE_BIT];
  assign posInputBufferEnable    = st.anaCfg[acr_pkg::POS_BUF_BIT];
  assign negInputBufferEnable    = st.anaCfg[acr_pkg::NEG_BUF_BIT];
  assign refBufferBypass         = st.refBypass;
  assign startOut                = st.startOut;
  assign resetOut                = st.resetOut;
  assign modulatorSaturationFlag = st.satFlag;
  assign irq                     = st.irq;
endmodule // acr_device

/* File: core/acr_host.sv */
// Purpose: host controller driving the converter clock block link
// Assumes: software port on the same clock
// Notes:   generates the external clock pin by a divider
`timescale 1ns/1ps
module acr_host
#(
  parameter int EXT_HALF = 1
)
(
  input  wire logic clock,
  input  wire logic rstn,
  acr_link_if.host  link,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  input  wire logic       startReq,
  input  wire logic       resetReq,
  output logic [7:0]      rdata,
  output logic            irq
);
  typedef struct packed {
    logic [3:0] devAddr;
    logic [7:0] devWdata;
    logic [7:0] devRdata;
    logic [2:0] ctrl;
    logic [2:0] intStat;
    logic [2:0] intMask;
    logic       linkWr;
    logic       linkRd;
    logic       rdPend;
    logic [7:0] halfCnt;
    logic       extClk;
    logic [2:0] holdCnt;
    logic       startPin;
    logic       resetPin;
    logic [7:0] rdata;
    logic       irq;
  } acr_host_s;

  acr_host_s st;
  acr_host_s next_st;
  logic      running;

  if (EXT_HALF < 1 || EXT_HALF > 256)
  begin : g_half_ok
    $error("EXT_HALF out of range");
  end

  always_comb
  begin
    next_st = st;
    next_st.linkWr = 1'b0;
    next_st.linkRd = 1'b0;
    next_st.startPin = startReq;
    next_st.resetPin = resetReq;
    // external clock pin, held after switching to oscillator
    running = st.ctrl[acr_pkg::CTRL_EXT_EN] || (st.holdCnt != 3'h0);
    if (running || st.extClk)
    begin
      if (st.halfCnt >= 8'(EXT_HALF - 1))
      begin
        next_st.halfCnt = 8'h00;
        next_st.extClk = !st.extClk;
        if (st.extClk && st.holdCnt != 3'h0)
          next_st.holdCnt = st.holdCnt - 3'h1;
      end
      else
        next_st.halfCnt = st.halfCnt + 8'h01;
    end
    // finished link read
    if (st.rdPend && !st.linkRd)
    begin
      next_st.rdPend = 1'b0;
      next_st.devRdata = link.linkRdata;
      next_st.intStat[acr_pkg::HINT_RD_DONE] = 1'b1;
    end
    if (st.linkWr)
      next_st.intStat[acr_pkg::HINT_WR_DONE] = 1'b1;
    if (wr)
    begin
      case (addr)
        acr_pkg::HOST_DEV_ADDR_REG:
          next_st.devAddr = wdata[3:0];
        acr_pkg::HOST_DEV_WDATA_REG:
        begin
          next_st.devWdata = wdata;
          next_st.linkWr = 1'b1;
          if (st.devAddr == acr_pkg::CLOCK_CONFIG_REG)
          begin
            if (st.ctrl[acr_pkg::CTRL_MAX_SPEED]
                && !wdata[acr_pkg::CLK_SEL_BIT])
            begin
              next_st.devWdata[acr_pkg::CLK_SEL_BIT] = 1'b1;
              next_st.intStat[acr_pkg::HINT_OVERRIDE] = 1'b1;
            end
            if (st.ctrl[acr_pkg::CTRL_DET_SYNC]
                && wdata[acr_pkg::DIV_LSB +: 3] != 3'h0)
            begin
              next_st.devWdata[acr_pkg::DIV_LSB +: 3] = 3'h0;
              next_st.intStat[acr_pkg::HINT_OVERRIDE] = 1'b1;
            end
            if (!next_st.devWdata[acr_pkg::CLK_SEL_BIT])
              next_st.holdCnt = 3'(acr_pkg::EXT_HOLD_EDGES + 1);
          end
        end
        acr_pkg::HOST_DEV_RD_REG:
        begin
          next_st.linkRd = 1'b1;
          next_st.rdPend = 1'b1;
        end
        acr_pkg::HOST_CTRL_REG:
          next_st.ctrl = wdata[2:0];
        acr_pkg::HOST_INT_STAT_REG:
          next_st.intStat = (st.intStat & ~wdata[2:0])
                            | (next_st.intStat & ~st.intStat);
        acr_pkg::HOST_INT_MASK_REG:
          next_st.intMask = wdata[2:0];
        default:
          next_st.devAddr = st.devAddr;
      endcase
    end
    next_st.rdata = 8'h00;
    if (rd)
    begin
      case (addr)
        acr_pkg::HOST_DEV_ADDR_REG:  next_st.rdata = {4'h0, st.devAddr};
        acr_pkg::HOST_DEV_WDATA_REG: next_st.rdata = st.devWdata;
        acr_pkg::HOST_DEV_RDATA_REG: next_st.rdata = st.devRdata;
        acr_pkg::HOST_CTRL_REG:      next_st.rdata = {5'h00, st.ctrl};
        acr_pkg::HOST_INT_STAT_REG:  next_st.rdata = {5'h00, st.intStat};
        acr_pkg::HOST_INT_MASK_REG:  next_st.rdata = {5'h00, st.intMask};
        acr_pkg::HOST_STATUS_REG:
          next_st.rdata = {5'h00, st.rdPend, st.holdCnt != 3'h0, running};
        default:                     next_st.rdata = 8'h00;
      endcase
    end
    next_st.irq = |(next_st.intStat & next_st.intMask);
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign link.linkWr    = st.linkWr;
  assign link.linkRd    = st.linkRd;
  assign link.linkAddr  = st.devAddr;
  assign link.linkWdata = st.devWdata;
  assign link.extClk    = st.extClk;
  assign link.startPin  = st.startPin;
  assign link.resetPin  = st.resetPin;
  assign rdata          = st.rdata;
  assign irq            = st.irq;
endmodule // acr_host

/* File: tb/acr_link_monitor.sv */
// Purpose: concurrent checks on the acr link and device outputs
// Assumes: one clock, rstn active low, extClk half period of one clock
// Notes:   quiet counts cycles since the clock select last moved
`timescale 1ns/1ps
module acr_link_monitor
(
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       linkWr,
  input wire logic       linkRd,
  input wire logic [3:0] linkAddr,
  input wire logic [7:0] linkWdata,
  input wire logic [7:0] linkRdata,
  input wire logic       extClk,
  input wire logic       startPin,
  input wire logic       resetPin,
  input wire logic       clkSrcExt,
  input wire logic       sysClkTick,
  input wire logic       modulatorClock,
  input wire logic       llOsrForceMid,
  input wire logic       inputRange2x,
  input wire logic       referenceRangeHigh,
  input wire logic       startOut
);
  logic [12:0] quiet;
  logic        prevSel;
  logic        expSel;
  logic        expForce;
  logic        wrCfg;
  assign wrCfg = linkWr && linkAddr == acr_pkg::CLOCK_CONFIG_REG;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      quiet    <= 13'h1FFF;
      prevSel  <= 1'b0;
      expSel   <= 1'b0;
      expForce <= 1'b0;
    end
    else
    begin
      prevSel <= clkSrcExt;
      if (clkSrcExt != prevSel)
        quiet <= 13'h0000;
      else if (quiet != 13'h1FFF)
        quiet <= quiet + 13'h0001;
      if (wrCfg)
      begin
        expSel   <= linkWdata[0];
        expForce <= linkWdata[3:1] == 3'h1 || linkWdata[3:1] >= 3'h4;
      end
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_rdata_window: assert property (!$past(linkRd) |-> linkRdata == 8'h00)
    else $error("read data outside its cycle");
  a_single_strobe: assert property (!(linkWr && linkRd))
    else $error("write and read strobes together");
  a_select_follows: assert property (wrCfg |->
    ##[2:3] clkSrcExt == expSel)
    else $error("clock select not taken");
  a_mod_half_sys: assert property ($changed(modulatorClock) |->
    (sysClkTick || $past(sysClkTick)))
    else $error("modulator clock moved without tick");
  a_reset_pin_osc: assert property ((resetPin && quiet == 13'h1FFF) |->
    ##[1:3] !clkSrcExt)
    else $error("reset pin left external select");
  a_ext_hold_four: assert property (
    (wrCfg && !linkWdata[0] && clkSrcExt) |->
    ##[1:4] $rose(extClk) ##[1:4] $rose(extClk)
    ##[1:4] $rose(extClk) ##[1:4] $rose(extClk))
    else $error("external clock stopped early");
  a_pins_ignored: assert property (
    (quiet >= 13'h0002 && quiet <= 13'h00C8) |-> !startOut)
    else $error("start passed during ignore");
  a_force_mid: assert property (wrCfg |->
    ##[2:3] llOsrForceMid == expForce)
    else $error("oversampling force wrong");
  a_range_one_x: assert property (referenceRangeHigh |-> !inputRange2x)
    else $error("two times range with high reference");
  a_start_passes: assert property ((startPin && quiet == 13'h1FFF)
    |=> startOut)
    else $error("start blocked after ignore");
  c_cfg_write: cover property (wrCfg);
  c_start_rise: cover property ($rose(startOut));
  c_ext_select: cover property ($rose(clkSrcExt));
endmodule // acr_link_monitor

/* File: tb/testbench.sv */
// Purpose: self-checking bench for host and device joined by the link
// Assumes: 40 MHz clock, oscillator modelled as 16/25 enable
// Notes:   software port driven by nonblocking writes after clock edges
`timescale 1ns/1ps
module testbench;
  logic       clock;
  logic       rstn;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic       startReq;
  logic       resetReq;
  logic       modSat;
  logic [7:0] rdata;
  logic       irq;
  logic       clkSrcExt;
  logic       sysClkTick;
  logic       modulatorClock;
  logic       llOsrForceMid;
  logic       inputRange2x;
  logic       referenceRangeHigh;
  logic       extendedRange;
  logic       posInputBufferEnable;
  logic       negInputBufferEnable;
  logic       refBufferBypass;
  logic       startOut;
  logic       resetOut;
  logic       modulatorSaturationFlag;
  logic       devIrq;
  int         miscompares;
  int         samplesChecked;
  acr_link_if link();
  acr_host acr_host_inst (.clock(clock), .rstn(rstn), .link(link),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .startReq(startReq),
    .resetReq(resetReq), .rdata(rdata), .irq(irq));
  acr_device acr_device_inst (.clock(clock), .rstn(rstn), .link(link),
    .modSat(modSat), .clkSrcExt(clkSrcExt), .sysClkTick(sysClkTick),
    .modulatorClock(modulatorClock), .llOsrForceMid(llOsrForceMid),
    .inputRange2x(inputRange2x), .referenceRangeHigh(referenceRangeHigh),
    .extendedRange(extendedRange),
    .posInputBufferEnable(posInputBufferEnable),
    .negInputBufferEnable(negInputBufferEnable),
    .refBufferBypass(refBufferBypass), .startOut(startOut),
    .resetOut(resetOut), .irq(devIrq),
    .modulatorSaturationFlag(modulatorSaturationFlag));
  acr_link_monitor acr_link_monitor_inst (.clock(clock), .rstn(rstn),
    .linkWr(link.linkWr), .linkRd(link.linkRd), .linkAddr(link.linkAddr),
    .linkWdata(link.linkWdata), .linkRdata(link.linkRdata),
    .extClk(link.extClk), .startPin(link.startPin),
    .resetPin(link.resetPin), .clkSrcExt(clkSrcExt),
    .sysClkTick(sysClkTick), .modulatorClock(modulatorClock),
    .llOsrForceMid(llOsrForceMid), .inputRange2x(inputRange2x),
    .referenceRangeHigh(referenceRangeHigh), .startOut(startOut));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] e, input logic [15:0] a);
    samplesChecked++;
    if (a !== e)
    begin
      miscompares++;
      $display("mismatch at %0t exp %h got %h", $time, e, a);
    end
  endtask
  task automatic hw(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic hr(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    rd <= 1'b1; addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic dev_wr(input logic [3:0] a, input logic [7:0] d);
    hw(acr_pkg::HOST_DEV_ADDR_REG, {4'h0, a});
    hw(acr_pkg::HOST_DEV_WDATA_REG, d);
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic dev_rd(input logic [3:0] a, output logic [7:0] d);
    hw(acr_pkg::HOST_DEV_ADDR_REG, {4'h0, a});
    hw(acr_pkg::HOST_DEV_RD_REG, 8'h00);
    repeat (3) @(posedge clock);
    hr(acr_pkg::HOST_DEV_RDATA_REG, d);
  endtask
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults;
    logic [7:0] d;
    dev_rd(acr_pkg::CLOCK_CONFIG_REG, d);
    chk(acr_pkg::CLOCK_CONFIG_RESET, d);
    chk(0, clkSrcExt);
    hr(4'hF, d);
    chk(0, d);
    $display("test defaults done");
  endtask
  task automatic t_analog;
    logic [5:0] v;
    int         n;
    int         bad;
    for (int i = 0; i < 64; i++)
    begin
      v = 6'(i);
      dev_wr(acr_pkg::ANALOG_CONFIG_REG, {2'b00, v});
      chk(v[0] & ~v[1], inputRange2x);
      chk(v[1], referenceRangeHigh);
      chk(v[2], extendedRange);
      chk(v[4:3], {negInputBufferEnable, posInputBufferEnable});
    end
    n = 0;
    bad = 0;
    repeat (200)
    begin
      @(posedge clock);
      #1 n += refBufferBypass;
      bad += refBufferBypass & ~modulatorClock;
    end
    chk(1, n > 0 && bad == 0);
    $display("test analog done");
  endtask
  task automatic t_divider;
    logic [7:0] d;
    int         n;
    int         e;
    for (int k = 0; k < 8; k++)
    begin
      dev_wr(acr_pkg::CLOCK_CONFIG_REG, {4'h0, 3'(k), 1'b0});
      chk(k == 1 || k >= 4, llOsrForceMid);
      n = 0;
      e = 640 >> (k > 4 ? 4 : k);
      repeat (1000)
      begin
        @(posedge clock);
        #1 n += sysClkTick;
      end
      chk(1, n >= e - 1 && n <= e + 1);
    end
    hw(acr_pkg::HOST_CTRL_REG, 8'h04);
    dev_wr(acr_pkg::CLOCK_CONFIG_REG, 8'h06);
    dev_rd(acr_pkg::CLOCK_CONFIG_REG, d);
    chk(8'h00, d);
    hw(acr_pkg::HOST_CTRL_REG, 8'h00);
    $display("test divider done");
  endtask
  task automatic t_clock;
    logic [7:0] d;
    hw(acr_pkg::HOST_CTRL_REG, 8'h03);
    dev_wr(acr_pkg::CLOCK_CONFIG_REG, 8'h00);
    chk(1, clkSrcExt);
    @(posedge clock) startReq <= 1'b1;
    repeat (100) @(posedge clock);
    #1 chk(0, startOut);
    dev_rd(acr_pkg::PRIMARY_STATUS_REG, d);
    chk(2'b11, d[2:1]);
    repeat (8200) @(posedge clock);
    #1 chk(1, startOut);
    @(posedge clock) startReq <= 1'b0;
    hw(acr_pkg::HOST_CTRL_REG, 8'h01);
    dev_wr(acr_pkg::CLOCK_CONFIG_REG, 8'h00);
    chk(0, clkSrcExt);
    hw(acr_pkg::HOST_CTRL_REG, 8'h00);
    repeat (8200) @(posedge clock);
    $display("test clock done");
  endtask
  task automatic t_reset_pin;
    logic [7:0] d;
    dev_wr(acr_pkg::CLOCK_CONFIG_REG, 8'h04);
    dev_wr(acr_pkg::ANALOG_CONFIG_REG, 8'h3F);
    @(posedge clock) resetReq <= 1'b1;
    repeat (3) @(posedge clock);
    resetReq <= 1'b0;
    #1 chk(1, resetOut);
    dev_rd(acr_pkg::CLOCK_CONFIG_REG, d);
    chk(8'h00, d);
    dev_rd(acr_pkg::ANALOG_CONFIG_REG, d);
    chk(8'h00, d);
    $display("test reset pin done");
  endtask
  task automatic t_sat;
    logic [7:0] d;
    dev_wr(acr_pkg::DEV_INT_MASK_REG, 8'h01);
    @(posedge clock) modSat <= 1'b1;
    repeat (300) @(posedge clock);
    #1 chk(1, modulatorSaturationFlag);
    chk(1, devIrq);
    dev_rd(acr_pkg::PRIMARY_STATUS_REG, d);
    chk(1, d[0]);
    @(posedge clock) modSat <= 1'b0;
    repeat (300) @(posedge clock);
    #1 chk(0, modulatorSaturationFlag);
    $display("test saturation done");
  endtask
  task automatic t_irq;
    logic [7:0] d;
    hw(acr_pkg::HOST_INT_STAT_REG, 8'h07);
    hw(acr_pkg::HOST_INT_MASK_REG, 8'h01);
    dev_wr(acr_pkg::ANALOG_CONFIG_REG, 8'h01);
    chk(1, irq);
    hr(acr_pkg::HOST_INT_STAT_REG, d);
    chk(8'h01, d);
    hw(acr_pkg::HOST_INT_STAT_REG, 8'h01);
    repeat (2) @(posedge clock);
    #1 chk(0, irq);
    hw(acr_pkg::HOST_INT_MASK_REG, 8'h00);
    dev_wr(acr_pkg::ANALOG_CONFIG_REG, 8'h00);
    chk(0, irq);
    hr(acr_pkg::HOST_INT_STAT_REG, d);
    chk(8'h01, d);
    $display("test interrupt done");
  endtask
  // ----------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial
  begin
    miscompares = 0;
    samplesChecked = 0;
    rstn = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    startReq = 1'b0;
    resetReq = 1'b0;
    modSat = 1'b0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    t_defaults();
    t_analog();
    t_divider();
    t_clock();
    t_reset_pin();
    t_sat();
    t_irq();
    end_sim();
  end
  initial
  begin
    repeat (60000) @(posedge clock);
    miscompares++;
    end_sim();
  end
endmodule // testbench
